/* File: fpp_pkg.sv */
`default_nettype none

package fpp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths

    localparam int unsigned PIN_W = 4;
    localparam int unsigned OUT_W = 3;
    localparam int unsigned ADR_W = 5;
    localparam int unsigned DAT_W = 32;

    ////////////////////////////////////////////////////////////////////////
    // register byte addresses

    localparam logic [4:0] ADR_PIN_STATE = 5'h00;
    localparam logic [4:0] ADR_DIRECTION = 5'h04;
    localparam logic [4:0] ADR_LATCH = 5'h08;
    localparam logic [4:0] ADR_ANALOG = 5'h0c;
    localparam logic [4:0] ADR_CONTROL = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // field positions and reset values

    localparam int unsigned INPUT_ONLY_BIT = 3;
    localparam int unsigned CTRL_MASTER_CLEAR_PIN_ENABLE_BIT = 0;
    localparam int unsigned LANE0_SEL = 0;
    localparam logic [2:0] RST_DIRECTION = 3'h7;
    localparam logic [2:0] RST_ANALOG = 3'h7;
    localparam logic [2:0] RST_LATCH = 3'h0;
    localparam logic RST_MASTER_CLEAR_PIN_ENABLE = 1'b0;
    localparam logic [3:0] RST_SYNC = 4'h0;
    localparam logic [2:0] RST_PIN_OUT = 3'h0;
    localparam logic [31:0] RST_DATA = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // types

    typedef struct packed {
        logic [2:0] seg_en;
        logic [2:0] seg_val;
        logic [2:0] ccp_en;
        logic [2:0] ccp_val;
    } fpp_periph_t;

    typedef enum logic {
        FPP_IDLE,
        FPP_ACK
    } fpp_bus_state_t;

endpackage : fpp_pkg

`default_nettype wire

/* File: fpp_port.sv */
// Summary of operation
// - four pin port, direction bits for pins two..zero only
// - direction 1 floats driver, 0 drives latch
// - bit three input only, direction reads one
// - reads give pins, writes go to latch
// - port write with lane zero dropped loads sampled pins into latch
// - master clear enabled forces bit three zero
// - analog select forces digital reads to zero
// - analog select leaves digital output untouched
// - direction still drives analog pins; software inputs
// - analog select resets set; software clears it
// - segment beats compare beats latch per pin
// - peripheral digital inputs stay live when output
// - port bits three..zero, upper bits zero
// - direction resets to input, bit three one
// - small variant hides three output pins
// - latch reads give stored value, not pins
// - analog select bits two..zero, reset one
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module fpp_port #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [fpp_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [fpp_pkg::DAT_W-1:0] dat_i,
    output logic [fpp_pkg::DAT_W-1:0] dat_o,
    output logic ack_o,
    input wire fpp_pkg::fpp_periph_t periph_i,
    input wire logic [fpp_pkg::PIN_W-1:0] pin_i,
    output logic [fpp_pkg::OUT_W-1:0] pin_o,
    output logic [fpp_pkg::OUT_W-1:0] pin_oe_o,
    output logic [fpp_pkg::PIN_W-1:0] dig_in_o,
    output logic [fpp_pkg::OUT_W-1:0] analog_en_o
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    fpp_pkg::fpp_bus_state_t state_reg;
    fpp_pkg::fpp_bus_state_t state_next;
    logic [2:0] direction_reg;
    logic [2:0] latch_reg;
    logic [2:0] analog_reg;
    logic master_clear_pin_enable_reg;
    logic [2:0] pin_out_reg;
    logic [2:0] pin_oe_reg;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic [3:0] pin_sync;
    logic [3:0] pin_read;
    logic [2:0] present;
    logic req;
    logic wr_go;
    logic lane0;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // highest enabled source wins the pin
    function automatic logic fpp_pick(
        input logic seg_en,
        input logic seg_val,
        input logic ccp_en,
        input logic ccp_val,
        input logic latch
    );
        if (seg_en) begin
            return seg_val;
        end else if (ccp_en) begin
            return ccp_val;
        end
        return latch;
    endfunction : fpp_pick

    function automatic logic [31:0] fpp_word(input logic [3:0] low);
        return {28'h000_0000, low};
    endfunction : fpp_word

    ////////////////////////////////////////////////////////////////////////
    // pin sampling

    fpp_sync fpp_sync_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .async_i(pin_i),
        .sync_o(pin_sync)
    );

    // output pins exist only on the large variant
    assign present = SMALL_VARIANT ? 3'h0 : 3'h7;

    always_comb begin
        pin_read[2:0] = pin_sync[2:0] & ~analog_reg & present;
        pin_read[fpp_pkg::INPUT_ONLY_BIT] =
            pin_sync[fpp_pkg::INPUT_ONLY_BIT] & ~master_clear_pin_enable_reg;
    end

    // peripherals see digital levels whatever the direction
    assign dig_in_o = pin_read;
    assign analog_en_o = analog_reg & present;

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave

    assign req = cyc_i && stb_i;
    assign lane0 = sel_i[fpp_pkg::LANE0_SEL];
    assign wr_go = ce_i && (state_reg == fpp_pkg::FPP_ACK) && req && we_i
        && lane0;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            fpp_pkg::FPP_IDLE: begin
                if (req) begin
                    state_next = fpp_pkg::FPP_ACK;
                end
            end
            fpp_pkg::FPP_ACK: begin
                state_next = fpp_pkg::FPP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= fpp_pkg::FPP_IDLE;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    assign ack_o = (state_reg == fpp_pkg::FPP_ACK);

    // read word; unmapped addresses answer with zero
    always_comb begin
        dat_next = fpp_pkg::RST_DATA;
        unique case (adr_i)
            fpp_pkg::ADR_PIN_STATE: begin
                dat_next = fpp_word(pin_read);
            end
            fpp_pkg::ADR_DIRECTION: begin
                dat_next = fpp_word({1'b1, direction_reg & present});
            end
            fpp_pkg::ADR_LATCH: begin
                dat_next = fpp_word({1'b0, latch_reg & present});
            end
            fpp_pkg::ADR_ANALOG: begin
                dat_next = fpp_word({1'b0, analog_reg & present});
            end
            fpp_pkg::ADR_CONTROL: begin
                dat_next = fpp_word({3'h0, master_clear_pin_enable_reg});
            end
            default: begin
                dat_next = fpp_pkg::RST_DATA;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= fpp_pkg::RST_DATA;
        end else if (ce_i && state_reg == fpp_pkg::FPP_IDLE && req) begin
            dat_reg <= dat_next;
        end
    end

    assign dat_o = dat_reg;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            direction_reg <= fpp_pkg::RST_DIRECTION;
        end else if (wr_go && adr_i == fpp_pkg::ADR_DIRECTION) begin
            direction_reg <= dat_i[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_reg <= fpp_pkg::RST_ANALOG;
        end else if (wr_go && adr_i == fpp_pkg::ADR_ANALOG) begin
            analog_reg <= dat_i[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_clear_pin_enable_reg <= fpp_pkg::RST_MASTER_CLEAR_PIN_ENABLE;
        end else if (wr_go && adr_i == fpp_pkg::ADR_CONTROL) begin
            master_clear_pin_enable_reg <= dat_i[fpp_pkg::CTRL_MASTER_CLEAR_PIN_ENABLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output latch

    // a port write is a read-modify-write: a dropped lane keeps pin levels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_reg <= fpp_pkg::RST_LATCH;
        end else if (ce_i && ack_o && req && we_i) begin
            if (adr_i == fpp_pkg::ADR_PIN_STATE) begin
                latch_reg <= lane0 ? dat_i[2:0] : pin_read[2:0];
            end else if (adr_i == fpp_pkg::ADR_LATCH && lane0) begin
                latch_reg <= dat_i[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers

    // analog select plays no part in driving
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_reg <= fpp_pkg::RST_PIN_OUT;
            pin_oe_reg <= fpp_pkg::RST_PIN_OUT;
        end else if (ce_i) begin
            for (int i = 0; i < fpp_pkg::OUT_W; i++) begin
                pin_out_reg[i] <= fpp_pick(periph_i.seg_en[i],
                    periph_i.seg_val[i], periph_i.ccp_en[i],
                    periph_i.ccp_val[i], latch_reg[i]);
            end
            pin_oe_reg <= ~direction_reg & present;
        end
    end

    assign pin_o = pin_out_reg;
    assign pin_oe_o = pin_oe_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_follows;
        ce_i && req && !ack_o |=> ack_o;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else
        $error("ack missing after request");

    property p_ack_drops;
        ack_o && ce_i |=> !ack_o;
    endproperty
    a_ack_drops: assert property (p_ack_drops) else
        $error("ack held two cycles");

    property p_dir_bit3;
        ack_o && !we_i && adr_i == fpp_pkg::ADR_DIRECTION |-> dat_o[3];
    endproperty
    a_dir_bit3: assert property (p_dir_bit3) else
        $error("input only direction not one");

    property p_dir_drive;
        wr_go && adr_i == fpp_pkg::ADR_DIRECTION ##1 ce_i
        |=> pin_oe_o == (~$past(dat_i[2:0], 2) & present);
    endproperty
    a_dir_drive: assert property (p_dir_drive) else
        $error("driver enable wrong after direction write");

    property p_port_write;
        wr_go && adr_i == fpp_pkg::ADR_PIN_STATE
        |=> latch_reg == $past(dat_i[2:0]);
    endproperty
    a_port_write: assert property (p_port_write) else
        $error("port write missed the latch");

    property p_rmw_merge;
        ce_i && ack_o && req && we_i && !lane0
        && adr_i == fpp_pkg::ADR_PIN_STATE
        |=> latch_reg == $past(pin_read[2:0]);
    endproperty
    a_rmw_merge: assert property (p_rmw_merge) else
        $error("read-modify-write did not merge pins");

    property p_master_clear_pin_enable_zero;
        master_clear_pin_enable_reg |-> !dig_in_o[fpp_pkg::INPUT_ONLY_BIT];
    endproperty
    a_master_clear_pin_enable_zero: assert property (p_master_clear_pin_enable_zero) else
        $error("input only pin visible with master clear");

    property p_analog_zero;
        ack_o && !we_i && adr_i == fpp_pkg::ADR_PIN_STATE
        && $stable(analog_reg) |-> (dat_o[2:0] & analog_reg) == 3'h0;
    endproperty
    a_analog_zero: assert property (p_analog_zero) else
        $error("analog pin read as one");

    property p_seg_first;
        ce_i && periph_i.seg_en[0] |=> pin_o[0] == $past(periph_i.seg_val[0]);
    endproperty
    a_seg_first: assert property (p_seg_first) else
        $error("segment output lost priority");

    property p_ccp_second;
        ce_i && !periph_i.seg_en[2] && periph_i.ccp_en[2]
        |=> pin_o[2] == $past(periph_i.ccp_val[2]);
    endproperty
    a_ccp_second: assert property (p_ccp_second) else
        $error("compare output lost priority");

    property p_upper_zero;
        ack_o && !we_i && adr_i == fpp_pkg::ADR_PIN_STATE
        |-> dat_o[31:4] == 28'h000_0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else
        $error("upper port bits not zero");

    property p_reset_vals;
        disable iff (1'b0)
        rst_i |=> direction_reg == fpp_pkg::RST_DIRECTION
            && analog_reg == fpp_pkg::RST_ANALOG;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else
        $error("direction or analog select reset wrong");

    property p_latch_last;
        ce_i && !periph_i.seg_en[0] && !periph_i.ccp_en[0]
        |=> pin_o[0] == $past(latch_reg[0]);
    endproperty
    a_latch_last: assert property (p_latch_last) else
        $error("latch lost pin zero with no peripheral");

    property p_small_quiet;
        SMALL_VARIANT |-> pin_oe_o == 3'h0 && analog_en_o == 3'h0;
    endproperty
    a_small_quiet: assert property (p_small_quiet) else
        $error("small variant drives or selects a pin");

    // clock enable low must hold the bus state, direction, latch and pin drivers
    property p_enable_freeze;
        !ce_i |=> $stable(state_reg) && $stable(direction_reg)
            && $stable(latch_reg) && $stable(pin_out_reg)
            && $stable(pin_oe_reg);
    endproperty
    a_enable_freeze: assert property (p_enable_freeze) else
        $error("state moved while clock enable low");

endmodule : fpp_port

`default_nettype wire

/* File: fpp_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module fpp_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [fpp_pkg::PIN_W-1:0] async_i,
    output logic [fpp_pkg::PIN_W-1:0] sync_o
);

    logic [fpp_pkg::PIN_W-1:0] meta_reg;
    logic [fpp_pkg::PIN_W-1:0] stage2_reg;
    logic [fpp_pkg::PIN_W-1:0] stage3_reg;
    logic [fpp_pkg::PIN_W-1:0] level_reg;

    ////////////////////////////////////////////////////////////////////////
    // three flops; only the second reads the first

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= fpp_pkg::RST_SYNC;
            stage2_reg <= fpp_pkg::RST_SYNC;
            stage3_reg <= fpp_pkg::RST_SYNC;
        end else if (ce_i) begin
            meta_reg <= async_i;
            stage2_reg <= meta_reg;
            stage3_reg <= stage2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a bit changes once the second and third stages agree

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_reg <= fpp_pkg::RST_SYNC;
        end else if (ce_i) begin
            for (int i = 0; i < fpp_pkg::PIN_W; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    level_reg[i] <= stage3_reg[i];
                end
            end
        end
    end

    assign sync_o = level_reg;

endmodule : fpp_sync

`default_nettype wire

/* File: test_four_pin_port_with_analog_select.sv */
`timescale 1ns/1ps
`default_nettype none

module test_four_pin_port_with_analog_select;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, rdat_s;
    logic ack, ack_s;
    fpp_pkg::fpp_periph_t periph = '0;
    logic [3:0] pin_in = 4'hf;
    logic [2:0] pin_out, pin_oe, analog_en, pin_out_s, pin_oe_s, analog_en_s;
    logic [3:0] dig_in, dig_in_s;
    logic [31:0] rd, rd_s;
    int errors = 0;
    int num_checks = 0;

    fpp_port #(.SMALL_VARIANT(1'b0)) fpp_port_i (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .periph_i(periph), .pin_i(pin_in), .pin_o(pin_out),
        .pin_oe_o(pin_oe), .dig_in_o(dig_in), .analog_en_o(analog_en));

    // reduced variant shares every input with the full one
    fpp_port #(.SMALL_VARIANT(1'b1)) fpp_port_small_i (.clk_i(clk_i),
        .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat_s),
        .ack_o(ack_s), .periph_i(periph), .pin_i(pin_in), .pin_o(pin_out_s),
        .pin_oe_o(pin_oe_s), .dig_in_o(dig_in_s), .analog_en_o(analog_en_s));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // shared tasks

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check

    // one classic cycle; read data taken at the edge where ack is seen
    task automatic wb(input logic w, input logic [4:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat;
        rd_s = rdat_s;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'h1);
    endtask : wr

    task automatic settle();
        repeat (5) @(posedge clk_i);
    endtask : settle

    ////////////////////////////////////////////////////////////////////////
    // scenarios

    task automatic test_reset();
        wb(1'b0, fpp_pkg::ADR_DIRECTION, 32'h0, 4'h1);
        check(rd, 32'h0000_000f);
        wb(1'b0, fpp_pkg::ADR_ANALOG, 32'h0, 4'h1);
        check(rd, 32'h0000_0007);
        check({29'h0, analog_en}, 32'h7);
        wb(1'b0, fpp_pkg::ADR_LATCH, 32'h0, 4'h1);
        check(rd, 32'h0);
        wb(1'b0, fpp_pkg::ADR_PIN_STATE, 32'h0, 4'h1);
        check(rd, 32'h0000_0008);
        check({29'h0, pin_oe}, 32'h0);
        wb(1'b0, 5'h14, 32'h0, 4'h1);
        check(rd, 32'h0);
        wb(1'b0, 5'h01, 32'h0, 4'h1);
        check(rd, 32'h0);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_drive();
        wr(fpp_pkg::ADR_ANALOG, 32'h0);
        wr(fpp_pkg::ADR_LATCH, 32'h5);
        wr(fpp_pkg::ADR_DIRECTION, 32'h0);
        settle();
        check({29'h0, pin_oe}, 32'h7);
        check({29'h0, pin_out}, 32'h5);
        wb(1'b0, fpp_pkg::ADR_DIRECTION, 32'h0, 4'h1);
        check(rd, 32'h8);
        wr(fpp_pkg::ADR_DIRECTION, 32'h6);
        settle();
        check({29'h0, pin_oe}, 32'h1);
        wb(1'b1, fpp_pkg::ADR_LATCH, 32'h2, 4'h0);
        wb(1'b0, fpp_pkg::ADR_LATCH, 32'h0, 4'h1);
        check(rd, 32'h5);
        wr(fpp_pkg::ADR_DIRECTION, 32'h0);
        wr(fpp_pkg::ADR_PIN_STATE, 32'h2);
        pin_in <= 4'h6;
        settle();
        wb(1'b0, fpp_pkg::ADR_PIN_STATE, 32'h0, 4'h1);
        check(rd, 32'h6);
        wb(1'b0, fpp_pkg::ADR_LATCH, 32'h0, 4'h1);
        check(rd, 32'h2);
        check({28'h0, dig_in}, 32'h6);
        wr(fpp_pkg::ADR_ANALOG, 32'h7);
        settle();
        check({29'h0, pin_out}, 32'h2);
        check({29'h0, pin_oe}, 32'h7);
        wb(1'b0, fpp_pkg::ADR_PIN_STATE, 32'h0, 4'h1);
        check(rd, 32'h0);
        $display("test_drive done");
    endtask : test_drive

    task automatic test_rmw();
        wr(fpp_pkg::ADR_DIRECTION, 32'h7);
        wr(fpp_pkg::ADR_ANALOG, 32'h0);
        pin_in <= 4'h5;
        settle();
        wb(1'b1, fpp_pkg::ADR_PIN_STATE, 32'h2, 4'h0);
        wb(1'b0, fpp_pkg::ADR_LATCH, 32'h0, 4'h1);
        check(rd, 32'h5);
        wr(fpp_pkg::ADR_ANALOG, 32'h1);
        wb(1'b1, fpp_pkg::ADR_PIN_STATE, 32'h0, 4'h0);
        wb(1'b0, fpp_pkg::ADR_LATCH, 32'h0, 4'h1);
        check(rd, 32'h4);
        $display("test_rmw done");
    endtask : test_rmw

    task automatic test_mclr();
        pin_in <= 4'hf;
        settle();
        wb(1'b0, fpp_pkg::ADR_PIN_STATE, 32'h0, 4'h1);
        check(rd, 32'he);
        wr(fpp_pkg::ADR_CONTROL, 32'h1);
        wb(1'b0, fpp_pkg::ADR_PIN_STATE, 32'h0, 4'h1);
        check(rd, 32'h6);
        check({28'h0, dig_in}, 32'h6);
        wr(fpp_pkg::ADR_CONTROL, 32'h0);
        $display("test_mclr done");
    endtask : test_mclr

    task automatic test_priority();
        wr(fpp_pkg::ADR_LATCH, 32'h7);
        wr(fpp_pkg::ADR_DIRECTION, 32'h0);
        periph <= '{seg_en: 3'h5, seg_val: 3'h1, ccp_en: 3'h6,
                    ccp_val: 3'h6};
        settle();
        check({29'h0, pin_out}, 32'h3);
        periph <= '{seg_en: 3'h0, seg_val: 3'h0, ccp_en: 3'h6,
                    ccp_val: 3'h2};
        settle();
        check({29'h0, pin_out}, 32'h3);
        check({29'h0, pin_oe}, 32'h7);
        $display("test_priority done");
    endtask : test_priority

    task automatic test_small();
        wb(1'b0, fpp_pkg::ADR_DIRECTION, 32'h0, 4'h1);
        check(rd_s, 32'h8);
        wb(1'b0, fpp_pkg::ADR_LATCH, 32'h0, 4'h1);
        check(rd_s, 32'h0);
        wb(1'b0, fpp_pkg::ADR_PIN_STATE, 32'h0, 4'h1);
        check(rd_s, 32'h8);
        check({26'h0, pin_oe_s, analog_en_s}, 32'h0);
        check({28'h0, dig_in_s}, 32'h8);
        $display("test_small done");
    endtask : test_small

    // clock enable low freezes the pin drivers
    task automatic test_enable();
        ce <= 1'b0;
        periph <= '{seg_en: 3'h7, seg_val: 3'h7, ccp_en: 3'h0,
                    ccp_val: 3'h0};
        settle();
        check({29'h0, pin_out}, 32'h3);
        ce <= 1'b1;
        settle();
        check({29'h0, pin_out}, 32'h7);
        periph <= '0;
        @(posedge clk_i);
        $display("test_enable done");
    endtask : test_enable

    // a reset in mid-run restores direction and analog select
    task automatic test_rereset();
        wr(fpp_pkg::ADR_DIRECTION, 32'h0);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, fpp_pkg::ADR_DIRECTION, 32'h0, 4'h1);
        check(rd, 32'h0000_000f);
        wb(1'b0, fpp_pkg::ADR_ANALOG, 32'h0, 4'h1);
        check(rd, 32'h0000_0007);
        check({29'h0, pin_oe}, 32'h0);
        $display("test_rereset done");
    endtask : test_rereset

    ////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        test_reset();
        test_drive();
        test_rmw();
        test_mclr();
        test_priority();
        test_enable();
        test_rereset();
        test_small();
        tally_and_finish();
    end

    initial begin
        repeat (3000) @(posedge clk_i);
        errors++;
        tally_and_finish();
    end

endmodule : test_four_pin_port_with_analog_select

`default_nettype wire
